// File: logic/ssa_device.sv
// Device end: sequencer of the serial sampling converter with shutdown.
// Assumes link pins are synchronous to clk and that the serial clock
// half period spans at least two clk cycles; the analog value to convert
// arrives on sample_in and is frozen at the hold point.
`timescale 1ns/1ps
module ssa_device
  import ssa_pkg::*;
(
  input  wire logic          clk,        // 40 MHz system clock
  input  wire logic          arst_n,     // Async reset, active low
  ssa_link_if.dev            link,       // Converter link
  input  wire logic [7:0]    sample_in,  // Value the converter resolves
  output logic               powered,    // Operating power drawn
  output logic               acq_window, // Sampler tracking input
  output logic               holding,    // Sampler in hold
  output logic               converting, // Conversion in progress
  output logic               single_or_differential, // Config bit one
  output logic               odd_sign,   // Config bit two
  output logic [7:0]         result      // Last held value
);
  import ssa_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ssa_dev_state_type st_q, st_d;
  logic        sclk_prev_q;
  logic [4:0]  rcnt_q, rcnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  res_q, res_d;
  logic        dout_q, dout_d;
  logic        oe_q, oe_d;
  logic        acq_q, acq_d;
  logic        hold_q, hold_d;
  logic        conv_q, conv_d;
  logic        sgl_q, sgl_d;
  logic        odd_q, odd_d;

  // Saturating increment keeps the edge count from wrapping when the
  // host clocks on past the result and zeros keep coming out
  function automatic logic [4:0] next_cnt(input logic [4:0] c);
    next_cnt = (c == POS_SAT) ? c : c + 5'h01;
  endfunction : next_cnt

  // ----------------------------------------------------------------
  // Link edge detection
  // ----------------------------------------------------------------
  // Both edges are gated by active; with chip select high the
  // serial clock and data can toggle freely and no edge is seen
  wire active  = !link.cs_n;
  wire rise    = active && link.sclk && !sclk_prev_q;
  wire fall    = active && !link.sclk && sclk_prev_q;
  wire [4:0] rcnt_n = next_cnt(rcnt_q);
  wire at_hold = fall && (st_q == DEV_SHIFT) && (rcnt_q == POS_DUM2);

  // Previous serial clock level, kept even in shutdown so that the
  // first edge after chip select falls is judged correctly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= link.sclk;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    rcnt_d = rcnt_q;
    sh_d   = sh_q;
    res_d  = res_q;
    dout_d = dout_q;
    oe_d   = oe_q;
    acq_d  = acq_q;
    hold_d = hold_q;
    conv_d = conv_q;
    sgl_d  = sgl_q;
    odd_d  = odd_q;
    if (!active) begin
      // Chip select high: back to waiting for a start bit, driver off
      st_d   = DEV_IDLE;
      rcnt_d = POS_START;
      sh_d   = 8'h00;
      dout_d = 1'b0;
      oe_d   = 1'b0;
      acq_d  = 1'b0;
      hold_d = 1'b0;
      conv_d = 1'b0;
    end else begin
      case (st_q)
        DEV_IDLE: begin
          // No recovery time is needed, so back-to-back exchanges
          // are limited only by the serial clock rate
          if (rise && link.din) begin
            st_d   = DEV_SHIFT;
            rcnt_d = POS_START;
          end
        end
        DEV_SHIFT: begin
          if (rise) begin
            rcnt_d = rcnt_n;
            if (rcnt_n == POS_SGL) sgl_d = link.din;
            if (rcnt_n == POS_ODD) begin
              odd_d = link.din;
              acq_d = 1'b1;
            end
          end
          if (at_hold) begin
            // Fall after the second dummy: freeze the input, start the
            // bit tests and take the data line from here on
            acq_d  = 1'b0;
            hold_d = 1'b1;
            conv_d = 1'b1;
            sh_d   = sample_in;
            res_d  = sample_in;
            oe_d   = 1'b1;
            dout_d = 1'b0;
            st_d   = DEV_CONV;
          end
        end
        DEV_CONV: begin
          if (rise) begin
            rcnt_d = rcnt_n;
            // Ninth rise after the hold fall is 8.5 clocks later
            if (rcnt_n == POS_CONV) begin
              conv_d = 1'b0;
              hold_d = 1'b0;
              st_d   = DEV_OUT;
            end
            if (rcnt_n >= POS_MSB) begin
              dout_d = sh_q[7];
              sh_d   = {sh_q[6:0], 1'b0};
            end else begin
              dout_d = 1'b0;
            end
          end
        end
        DEV_OUT: begin
          // Serial input is ignored until chip select rises again;
          // once the shifter is empty only zeros come out
          if (rise) begin
            rcnt_d = rcnt_n;
            dout_d = sh_q[7];
            sh_d   = {sh_q[6:0], 1'b0};
          end
        end
        default: begin
          st_d = DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= DEV_IDLE;
      rcnt_q <= POS_START;
      sh_q   <= 8'h00;
      res_q  <= 8'h00;
      {dout_q, oe_q, acq_q, hold_q, conv_q} <= 5'h00;
      {sgl_q, odd_q} <= 2'h0;
    end else begin
      st_q   <= st_d;
      rcnt_q <= rcnt_d;
      sh_q   <= sh_d;
      res_q  <= res_d;
      {dout_q, oe_q, acq_q, hold_q, conv_q} <= {dout_d, oe_d, acq_d, hold_d, conv_d};
      {sgl_q, odd_q} <= {sgl_d, odd_d};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Power follows the pin directly; a registered copy would keep the
  // converter up one cycle into shutdown for no gain
  assign powered    = active;
  assign acq_window = acq_q;
  assign holding    = hold_q;
  assign converting = conv_q;
  assign single_or_differential = sgl_q;
  assign odd_sign   = odd_q;
  assign result     = res_q;
  assign link.dout    = dout_q;
  assign link.dout_oe = oe_q;
endmodule : ssa_device

// File: logic/ssa_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty come from pointers with a wrap bit.
`timescale 1ns/1ps
module ssa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,        // System clock
  input  wire logic             arst_n,     // Async reset, active low
  input  wire logic             in_valid,   // Word offered
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Word in
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Consumer takes word
  output logic [WIDTH-1:0]      out_data    // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign in_ready  = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Storage has no reset; only pointers need a defined start
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
    end
  end
endmodule : ssa_fifo

// File: logic/ssa_host.sv
// Host end: runs one exchange per order, or back to back while auto is set, makes
// the serial clock by a divider and queues each 8-bit result in a FIFO read by software.
// Assumes the device end answers on the link as the converter does.
`timescale 1ns/1ps
module ssa_host
  import ssa_pkg::*;
(
  input  wire logic                  clk,      // 40 MHz system clock
  input  wire logic                  arst_n,   // Async reset, active low
  input  wire logic [ssa_pkg::ADDR_W-1:0] addr, // Register address
  input  wire logic [31:0]           wdata,    // Write data
  input  wire logic                  wr,       // Write strobe
  input  wire logic                  rd,       // Read strobe
  output logic [31:0]                rdata,    // Read data, cycle after rd
  ssa_link_if.host                   link      // Converter link
);
  import ssa_pkg::*;

  ssa_hst_state_type st_q;
  logic [DIV_W-1:0]  div_q;
  logic [DIV_W-1:0]  hc_q;
  logic [4:0]        ecnt_q;
  logic [7:0]        res_q;
  logic              cs_n_q, sclk_q, din_q;
  logic              go_q, sgl_q, odd_q, auto_q, push_q;
  logic [31:0]       rdata_q;
  logic              f_in_ready, f_out_valid;
  logic [7:0]        f_out_data;

  // Bit placed on din for rising-edge index idx
  function automatic logic din_bit(input logic [4:0] idx, input logic s,
                                   input logic o);
    din_bit = (idx == POS_START) | ((idx == POS_SGL) & s) | ((idx == POS_ODD) & o);
  endfunction : din_bit

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_ctrl = wr && (addr == ADDR_CTRL);
  wire wr_div  = wr && (addr == ADDR_DIV);
  wire rd_data = rd && (addr == ADDR_DATA);
  wire tick    = (hc_q + 1'b1) >= div_q;
  wire start   = (st_q == HST_IDLE) && (go_q || auto_q) && f_in_ready;
  wire rise    = (st_q == HST_RUN) && tick && !sclk_q;
  wire fall    = (st_q == HST_RUN) && tick && sclk_q;
  // Divider below the 5V limit is raised to it; 3V users write HALF_3V
  wire [DIV_W-1:0] div_w = (wdata[DIV_W-1:0] < HALF_MIN) ? HALF_MIN : wdata[DIV_W-1:0];
  wire [31:0] rmux = (addr == ADDR_CTRL) ? {28'h0, auto_q, odd_q, sgl_q, go_q} :
                     (addr == ADDR_DIV)  ? {24'h0, div_q} :
                     (addr == ADDR_STAT) ? {29'h0, f_out_valid, !f_in_ready,
                                            st_q != HST_IDLE} :
                     (addr == ADDR_DATA) ? {23'h0, f_out_valid, f_out_data} : 32'h0;

  // Control registers; a new order wins over the clear by a start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {go_q, sgl_q, odd_q, auto_q} <= 4'h0;
      div_q   <= HALF_MIN;
      rdata_q <= 32'h0;
    end else begin
      go_q    <= (wr_ctrl && wdata[CTRL_GO]) || (go_q && !start);
      sgl_q   <= wr_ctrl ? wdata[CTRL_SGL] : sgl_q;
      odd_q   <= wr_ctrl ? wdata[CTRL_ODD] : odd_q;
      auto_q  <= wr_ctrl ? wdata[CTRL_AUTO] : auto_q;
      div_q   <= wr_div ? div_w : div_q;
      rdata_q <= rd ? rmux : 32'h0;
    end
  end

  // Exchange sequencer: chip select low only for the exchange itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= HST_IDLE;
      {cs_n_q, sclk_q, din_q, push_q} <= 4'h8;
      hc_q <= '0;
      ecnt_q <= '0;
      res_q <= '0;
    end else begin
      push_q <= 1'b0;
      hc_q   <= (st_q == HST_IDLE || tick) ? '0 : hc_q + 1'b1;
      case (st_q)
        HST_IDLE: if (start) begin
          st_q <= HST_RUN;
          cs_n_q <= 1'b0;
          sclk_q <= 1'b0;
          din_q  <= din_bit(POS_START, sgl_q, odd_q);
          ecnt_q <= POS_START;
        end
        HST_RUN: if (rise) begin
          sclk_q <= 1'b1;
          ecnt_q <= ecnt_q + 1'b1;
          if (ecnt_q > POS_MSB) res_q <= {res_q[6:0], link.dout_line};
        end else if (fall) begin
          sclk_q <= 1'b0;
          din_q  <= din_bit(ecnt_q, sgl_q, odd_q);
          if (ecnt_q > POS_LAST) begin
            st_q <= HST_GAP;
            cs_n_q <= 1'b1;
            push_q <= 1'b1;
          end
        end
        // Clock and data are left high while deselected, so the device
        // sees a rise with a one on din that it must ignore; the start
        // edge brings the clock back low in the same cycle as chip select
        HST_GAP: if (tick) begin
          st_q   <= HST_IDLE;
          sclk_q <= 1'b1;
          din_q  <= 1'b1;
        end
        default: st_q <= HST_IDLE;
      endcase
    end
  end

  // Room was checked at start, so the push is never refused
  ssa_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .arst_n   (arst_n),
    .in_valid (push_q),
    .in_ready (f_in_ready),
    .in_data  (res_q),
    .out_valid(f_out_valid),
    .out_ready(rd_data),
    .out_data (f_out_data)
  );

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din  = din_q;
  assign rdata     = rdata_q;
endmodule : ssa_host

// File: logic/ssa_link_if.sv
// Serial link between the converter device and its host controller.
// The host makes chip select, serial clock and serial input; the device
// drives the serial output only while its enable is high.
`timescale 1ns/1ps
interface ssa_link_if;
  logic cs_n;     // Chip select, low while an exchange runs
  logic sclk;     // Serial clock from host
  logic din;      // Host to device serial data
  logic dout;     // Device to host serial data
  logic dout_oe;  // Device drives dout while high
  wire  dout_line = dout_oe ? dout : 1'b0;  // Level the host sees

  modport dev  (input cs_n, sclk, din, output dout, dout_oe);
  modport host (output cs_n, sclk, din, input dout_line);
endinterface : ssa_link_if

// File: logic/ssa_pkg.sv
// Shared constants for the serial sampling converter link: bit positions
// of the exchange, clock-rate limits, host register map and state types.
// Assumes a 40 MHz system clock on both ends of the link.
package ssa_pkg;

  // ----------------------------------------------------------------
  // Exchange layout, counted in serial-clock rising edges after start
  // ----------------------------------------------------------------
  localparam int          RES_BITS  = 8;
  localparam logic [4:0]  POS_START = 5'h00;  // Start bit edge
  localparam logic [4:0]  POS_SGL   = 5'h01;  // Single/differential bit
  localparam logic [4:0]  POS_ODD   = 5'h02;  // Odd/sign bit, window opens
  localparam logic [4:0]  POS_DUM2  = 5'h04;  // Second dummy bit
  localparam logic [4:0]  POS_MSB   = 5'h07;  // First result bit driven
  localparam logic [4:0]  POS_CONV  = 5'h0D;  // 8.5 clocks after hold
  localparam logic [4:0]  POS_LAST  = 5'h0F;  // Host samples the LSB here
  localparam logic [4:0]  POS_SAT   = 5'h1F;  // Edge counter ceiling

  // ----------------------------------------------------------------
  // Clock rates in kHz and the derived serial half periods
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 40000;
  localparam int SCLK_5V_KHZ  = 14400;
  localparam int SCLK_3V_KHZ  = 5400;
  localparam int RATE_KHZ     = 1000;
  localparam int HALF_MIN_INT = (CLK_KHZ + 2 * SCLK_5V_KHZ - 1) / (2 * SCLK_5V_KHZ);
  localparam int HALF_3V_INT  = (CLK_KHZ + 2 * SCLK_3V_KHZ - 1) / (2 * SCLK_3V_KHZ);
  localparam int DIV_W        = 8;
  localparam logic [DIV_W-1:0] HALF_MIN = DIV_W'(HALF_MIN_INT);
  localparam logic [DIV_W-1:0] HALF_3V  = DIV_W'(HALF_3V_INT);

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DIV  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_DATA = 4'hC;
  localparam int CTRL_GO   = 0;
  localparam int CTRL_SGL  = 1;
  localparam int CTRL_ODD  = 2;
  localparam int CTRL_AUTO = 3;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    DEV_IDLE  = 4'h1,
    DEV_SHIFT = 4'h2,
    DEV_CONV  = 4'h4,
    DEV_OUT   = 4'h8
  } ssa_dev_state_type;

  typedef enum logic [2:0] {
    HST_IDLE = 3'h1,
    HST_RUN  = 3'h2,
    HST_GAP  = 3'h4
  } ssa_hst_state_type;

endpackage : ssa_pkg

// File: testbench/serial_adc_shutdown_sampler_tb_top.sv
// Self-checking bench: host and device joined by the link interface and
// driven through the host register port. Assumes the design is compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module serial_adc_shutdown_sampler_tb_top;
  import ssa_pkg::*;
  typedef struct {logic sgl; logic odd; logic [7:0] smp;} ssa_row_type;

  logic        clk;
  logic        arst_n;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [7:0]  sample_in;
  logic        powered;
  logic        acq_window;
  logic        holding;
  logic        converting;
  logic        single_or_differential;
  logic        odd_sign;
  logic [7:0]  result;
  logic [31:0] rd_val;
  int          failures;
  int          compares;
  int          n;
  ssa_row_type rows [4] = '{'{1'b0, 1'b0, 8'h00}, '{1'b1, 1'b0, 8'hFF},
                            '{1'b0, 1'b1, 8'hA5}, '{1'b1, 1'b1, 8'h3C}};

  ssa_link_if u_link();

  ssa_host u_ssa_host (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(u_link));
  ssa_device u_ssa_device (.clk(clk), .arst_n(arst_n), .link(u_link), .sample_in(sample_in),
    .powered(powered), .acq_window(acq_window), .holding(holding), .converting(converting),
    .single_or_differential(single_or_differential), .odd_sign(odd_sign), .result(result));
  ssa_link_sva u_ssa_link_sva (.clk(clk), .arst_n(arst_n), .cs_n(u_link.cs_n),
    .sclk(u_link.sclk), .dout_oe(u_link.dout_oe), .dout_line(u_link.dout_line),
    .powered(powered), .acq_window(acq_window), .holding(holding),
    .converting(converting), .result(result));

  // ------------------------------------------------------------
  // Clock and register bus tasks
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // One idle cycle between strobes keeps each strobe assigned once per step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // Polls one status bit until it equals the wanted level, bounded
  task automatic wait_stat(input int bit_idx, input logic lvl);
    n = 0;
    rd_reg(ADDR_STAT, rd_val);
    while (rd_val[bit_idx] !== lvl && n < 3000) begin
      rd_reg(ADDR_STAT, rd_val);
      n++;
    end
    `CHK(rd_val[bit_idx], lvl)
  endtask : wait_stat

  // One exchange ordered by software, then the result popped and checked
  task automatic run_row(input ssa_row_type r);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[CTRL_GO] = 1'b1;
    c[CTRL_SGL] = r.sgl;
    c[CTRL_ODD] = r.odd;
    @(posedge clk);
    sample_in <= r.smp;
    wr_reg(ADDR_CTRL, c);
    wait_stat(0, 1'b0);
    rd_reg(ADDR_DATA, rd_val);
    `CHK(rd_val[8:0], {1'b1, r.smp})
    `CHK(single_or_differential, r.sgl)
    `CHK(odd_sign, r.odd)
    `CHK(powered, 1'b0)
  endtask : run_row

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    sample_in = 8'h00;
    repeat (8) @(posedge clk);
    `CHK(u_link.cs_n, 1'b1)
    `CHK(powered, 1'b0)
    `CHK(u_link.dout_oe, 1'b0)
    arst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) run_row(rows[i]);
    $display("test rows done");
    // Unmapped place, clamped divider, empty queue
    wr_reg(4'h2, 32'hFFFF_FFFF);
    rd_reg(4'h2, rd_val);
    `CHK(rd_val, 32'h0000_0000)
    wr_reg(ADDR_DIV, 32'h0000_0000);
    rd_reg(ADDR_DIV, rd_val);
    `CHK(rd_val[DIV_W-1:0], HALF_MIN)
    rd_reg(ADDR_DATA, rd_val);
    `CHK(rd_val[8], 1'b0)
    $display("test registers done");
    // Slower serial clock for a lowered supply still converts
    wr_reg(ADDR_DIV, 32'(HALF_3V));
    run_row(rows[2]);
    wr_reg(ADDR_DIV, 32'(HALF_MIN));
    $display("test slow clock done");
    // Continuous exchanges fill the queue until it refuses more
    sample_in <= 8'h5A;
    wr_reg(ADDR_CTRL, 32'h0000_0008);
    rd_reg(ADDR_CTRL, rd_val);
    `CHK(rd_val, 32'h0000_0008)
    wait_stat(1, 1'b1);
    wr_reg(ADDR_CTRL, 32'h0000_0000);
    wait_stat(0, 1'b0);
    // Idle, full and holding data all at once
    rd_reg(ADDR_STAT, rd_val);
    `CHK(rd_val, 32'h0000_0006)
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      rd_reg(ADDR_DATA, rd_val);
      `CHK(rd_val[8:0], 9'h15A)
    end
    rd_reg(ADDR_DATA, rd_val);
    `CHK(rd_val[8], 1'b0)
    `CHK(powered, 1'b0)
    $display("test fifo fill done");
    // Reset in mid conversion drops chip select and the driver at once
    wr_reg(ADDR_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk);
    `CHK(holding, 1'b1)
    arst_n <= 1'b0;
    @(posedge clk);
    `CHK(u_link.cs_n, 1'b1)
    `CHK(u_link.dout_oe, 1'b0)
    `CHK(holding, 1'b0)
    `CHK(converting, 1'b0)
    `CHK(powered, 1'b0)
    `CHK(result, 8'h00)
    arst_n <= 1'b1;
    run_row(rows[3]);
    $display("test mid reset done");
    report_and_stop();
  end

  // Whole run needs a few thousand cycles; this margin covers it well
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("Error at %0t ns: watchdog got %0h expected %0h", $time, 0, 1);
    report_and_stop();
  end

endmodule : serial_adc_shutdown_sampler_tb_top

// File: testbench/ssa_link_sva.sv
// Concurrent checks on the converter link and the device status pins.
// Assumes one clock domain and a host that sends the start bit at rise 0.
`timescale 1ns/1ps
module ssa_link_sva (
  input wire logic       clk,        // System clock
  input wire logic       arst_n,     // Async reset, active low
  input wire logic       cs_n,       // Chip select
  input wire logic       sclk,       // Serial clock
  input wire logic       dout_oe,    // Device output enable
  input wire logic       dout_line,  // Level the host sees
  input wire logic       powered,    // Device power state
  input wire logic       acq_window, // Sampler tracking
  input wire logic       holding,    // Sampler in hold
  input wire logic       converting, // Conversion running
  input wire logic [7:0] result      // Held value
);
  // ------------------------------------------------------------
  // Serial rise counter
  // ------------------------------------------------------------
  logic       sclk_q;
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  logic       rise_seen;

  // Saturates so that endless clocking with chip select low cannot wrap
  assign rise_seen = sclk && !sclk_q && (rises_q != 5'h1F);
  assign rises_d   = cs_n ? 5'h00 : (rise_seen ? rises_q + 5'h01 : rises_q);

  // Seen on the same clk edge as the device, so counts line up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q  <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sclk_q  <= sclk;
      rises_q <= rises_d;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence hold_point_s;
    $rose(holding);
  endsequence
  sequence window_open_s;
    $rose(acq_window);
  endsequence

  power_follows_cs_a: assert property (powered == !cs_n)
    else $error("power state differs from chip select");
  shutdown_quiet_a: assert property (cs_n && $past(cs_n) |->
    !dout_oe && !acq_window && !holding && !converting)
    else $error("device active while deselected");
  window_open_a: assert property (window_open_s |-> rises_q == 5'h03)
    else $error("window opened at wrong bit");
  window_close_a: assert property ($fell(acq_window) |-> $rose(holding))
    else $error("window closed without hold");
  hold_point_a: assert property (hold_point_s |->
    rises_q == 5'h05 && !sclk && converting && dout_oe)
    else $error("hold not on fall after second dummy");
  conv_steady_a: assert property (hold_point_s |-> converting[*8])
    else $error("conversion cut short");
  conv_length_a: assert property ($fell(converting) && !cs_n |-> rises_q == 5'h0E)
    else $error("conversion length wrong");
  null_bits_a: assert property (!cs_n && rises_q <= 5'h07 |-> !dout_line)
    else $error("null bits not zero");
  msb_first_a: assert property (!cs_n && rises_q >= 5'h08 && rises_q <= 5'h0F |->
    dout_line == result[3'(5'h0F - rises_q)])
    else $error("result bit out of order");
  zero_tail_a: assert property (!cs_n && rises_q >= 5'h10 |-> !dout_line)
    else $error("tail not zero");

  hold_seen_c: cover property (hold_point_s);

endmodule : ssa_link_sva
